// [codec_cascade_port.sv]
// Purpose: cascadable converter serial port, mixed mode and DAC timing
// Assumes: converter logic on CLK_I supplies ADC words; one clock
// Notes:   control words addressed here reach the port's own registers
`timescale 1ns/1ps

// How it works
// - mixed mode accepts DAC words and control words, each handled by type.
// - in mixed mode only MSB-zero words advance the frame counter.
// - DAC loads from holding register just before ADC word goes out.
// - DAC advance setting moves the DAC load earlier.
// - output frame sync rises, then sixteen ADC bits shift out.
// - the DAC word that brings the counter to the device count moves into the DAC holding register.
// - mixed mode checks each word's MSB for DAC or control.
// - control word with nonzero address is decremented and forwarded.
// - counter reaching device count updates holding register, then clears.
module codec_cascade_port
	import codec_port_pkg::*;
#(
	parameter int SAMPLE_PERIOD = SAMPLE_CYCLES,
	parameter int ADV_STEP      = ADV_STEP_CYCLES,
	parameter int HALF_DIV      = SCLK_HALF_DIV
)(
	input  wire logic                               CLK_I,
	input  wire logic                               RESET_I,
	input  wire logic [codec_port_pkg::ADDR_W-1:0]  ADDR_I,
	input  wire logic [codec_port_pkg::WORD_W-1:0]  WDATA_I,
	input  wire logic                               WR_I,
	input  wire logic                               RD_I,
	output logic      [codec_port_pkg::WORD_W-1:0]  RDATA_O,
	output logic                                    SERIAL_CLOCK_O,
	output logic                                    SERIAL_DATA_O,
	output logic                                    OUTPUT_FRAME_SYNC_O,
	input  wire logic                               SERIAL_DATA_I,
	input  wire logic                               INPUT_FRAME_SYNC_I,
	input  wire logic [codec_port_pkg::WORD_W-1:0]  ADC_DATA_I,
	output logic                                    ADC_SAMPLE_O,
	output logic      [codec_port_pkg::WORD_W-1:0]  DAC_DATA_O,
	output logic                                    DAC_LOAD_O
);
	import codec_port_pkg::*;

	serial_link_if lnk ();

	logic [CTRL_W-1:0]    ctrl_q;
	logic [ADV_W-1:0]     adv_q;
	logic [SAMP_W-1:0]    samp_q;
	logic [SAMP_W-1:0]    load_at;
	logic                 adc_event;
	logic                 dac_event;
	logic [CNT_W-1:0]     fcount_q;
	logic [CNT_W-1:0]     fcount_d;
	logic [WORD_W-1:0]    hold_q;
	logic                 adc_pend_q;
	logic [WORD_W-1:0]    adc_word_q;
	logic                 fwd_pend_q;
	logic [WORD_W-1:0]    fwd_word_q;
	logic                 program_or_data_select;
	logic                 mixed_mode_bit;
	logic [CNT_W-1:0]     dev_count;
	logic                 rx_ctrl;
	logic                 rx_dac;
	logic [CW_ADDR_W-1:0] rx_addr;
	logic [CW_REG_W-1:0]  rx_reg;
	logic                 rx_read;
	logic                 rx_ours;
	logic                 ser_wr;
	logic                 dac_hit;
	logic                 fwd_set;
	logic [WORD_W-1:0]    fwd_val;
	logic [WORD_W-1:0]    rd_val;

	// ==========================================================
	// register read decode, shared by bus and serial reads
	function automatic logic [WORD_W-1:0] reg_value(
		input logic [ADDR_W-1:0] a
	);
		logic [WORD_W-1:0] v;
		v = '0;
		unique case (a)
			REG_CTRL:     v = WORD_W'(ctrl_q);
			REG_DAC_ADV:  v = WORD_W'(adv_q);
			REG_STATUS:   v = WORD_W'({lnk.tx_busy, fcount_q});
			REG_DAC_HOLD: v = hold_q;
			default:      v = '0;
		endcase
		return v;
	endfunction

	// ==========================================================
	// control field view
	assign program_or_data_select = ctrl_q[CTRL_PGM_BIT];
	assign mixed_mode_bit         = ctrl_q[CTRL_MM_BIT];
	assign dev_count              = ctrl_q[CTRL_CNT_LSB +: CNT_W];

	// ==========================================================
	// incoming word classification
	// msb selects type in mixed mode
	assign rx_ctrl = !program_or_data_select
		| (mixed_mode_bit & lnk.rx_word[CW_TYPE_BIT]);
	// each word handled by its type
	assign rx_dac  = lnk.rx_done & !rx_ctrl;
	assign rx_addr = lnk.rx_word[CW_ADDR_LSB +: CW_ADDR_W];
	assign rx_reg  = lnk.rx_word[CW_REG_LSB +: CW_REG_W];
	assign rx_read = lnk.rx_word[CW_READ_BIT];
	assign rx_ours = lnk.rx_done & rx_ctrl & (rx_addr == '0);
	assign ser_wr  = rx_ours & !rx_read;

	// ==========================================================
	// frame counting for DAC update
	// only DAC words count
	assign fcount_d = fcount_q + CNT_W'(1);
	assign dac_hit  = rx_dac & (fcount_d == dev_count);

	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
			fcount_q <= '0;
		else if (rx_dac)
			fcount_q <= dac_hit ? '0 : fcount_d;
	end

	// ==========================================================
	// DAC holding register
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
			hold_q <= '0;
		else if (dac_hit)
			hold_q <= lnk.rx_word;
	end

	// ==========================================================
	// register value returned by a serial read
	assign rd_val = reg_value(ADDR_W'(rx_reg));

	// ==========================================================
	// words passed downstream
	// a newer word replaces a forward that is still waiting
	always_comb
	begin
		fwd_set = 1'b0;
		fwd_val = lnk.rx_word;
		if (rx_dac && !dac_hit)
		begin
			fwd_set = 1'b1;
		end
		else if (lnk.rx_done && rx_ctrl && rx_addr != '0)
		begin
			fwd_set = 1'b1;
			fwd_val[CW_ADDR_LSB +: CW_ADDR_W] = rx_addr - CW_ADDR_W'(1);
		end
		else if (rx_ours && rx_read)
		begin
			fwd_set = 1'b1;
			fwd_val[BYTE_W-1:0] = rd_val[BYTE_W-1:0];
		end
	end

	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			fwd_pend_q <= 1'b0;
			fwd_word_q <= '0;
		end
		else if (fwd_set)
		begin
			fwd_pend_q <= 1'b1;
			fwd_word_q <= fwd_val;
		end
		else if (!lnk.tx_busy && !adc_pend_q)
		begin
			fwd_pend_q <= 1'b0;
		end
	end

	// ==========================================================
	// sample timing and DAC load point
	// advance times step must stay below the sample period
	assign adc_event = (samp_q == SAMP_W'(SAMPLE_PERIOD - 1));
	assign load_at   = SAMP_W'(SAMPLE_PERIOD - 1)
		- SAMP_W'(32'(adv_q) * ADV_STEP);
	// load just before ADC word out
	assign dac_event = (samp_q == load_at);

	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
			samp_q <= '0;
		else
			samp_q <= adc_event ? '0 : samp_q + SAMP_W'(1);
	end

	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			DAC_DATA_O <= '0;
			DAC_LOAD_O <= 1'b0;
		end
		else
		begin
			DAC_LOAD_O <= dac_event;
			if (dac_event)
				DAC_DATA_O <= hold_q;
		end
	end

	// ==========================================================
	// ADC word capture, queued one cycle after the ADC_SAMPLE_O strobe
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			adc_pend_q   <= 1'b0;
			adc_word_q   <= '0;
			ADC_SAMPLE_O <= 1'b0;
		end
		else
		begin
			ADC_SAMPLE_O <= adc_event;
			if (ADC_SAMPLE_O)
			begin
				// new ADC word queued for output
				adc_pend_q <= 1'b1;
				adc_word_q <= ADC_DATA_I;
			end
			else if (!lnk.tx_busy)
			begin
				adc_pend_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// transmit arbitration: ADC word before forwarded words
	assign lnk.tx_load = adc_pend_q | fwd_pend_q;
	assign lnk.tx_word = adc_pend_q ? adc_word_q : fwd_word_q;

	// ==========================================================
	// control and advance registers; serial writes win
	// a bus write in the cycle of a serial write is lost
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			ctrl_q <= CTRL_RESET;
			adv_q  <= ADV_RESET;
		end
		else if (ser_wr)
		begin
			if (rx_reg == CW_REG_CTRL)
				ctrl_q <= lnk.rx_word[CTRL_W-1:0];
			if (rx_reg == CW_REG_ADV)
				adv_q <= lnk.rx_word[ADV_W-1:0];
		end
		else if (WR_I)
		begin
			if (ADDR_I == REG_CTRL)
				ctrl_q <= WDATA_I[CTRL_W-1:0];
			if (ADDR_I == REG_DAC_ADV)
				adv_q <= WDATA_I[ADV_W-1:0];
		end
	end

	// ==========================================================
	// register read port
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
			RDATA_O <= '0;
		else if (RD_I)
			RDATA_O <= reg_value(ADDR_I);
	end

	// ==========================================================
	// serial shifter
	serial_engine #(
		.HALF_DIV (HALF_DIV)
	) u_engine (
		.clk_i   (CLK_I),
		.reset_i (RESET_I),
		.lnk     (lnk),
		.sclk_o  (SERIAL_CLOCK_O),
		.sdata_o (SERIAL_DATA_O),
		.ofs_o   (OUTPUT_FRAME_SYNC_O),
		.sdata_i (SERIAL_DATA_I),
		.ifs_i   (INPUT_FRAME_SYNC_I)
	);
endmodule // codec_cascade_port

// [codec_port_pkg.sv]
// Purpose: shared constants for the cascadable converter serial port
// Assumes: one 25 MHz clock; 16-bit serial words
// Notes:   register offsets are word indices on the plain register port
package codec_port_pkg;
	// ==========================================================
	// word and bus geometry
	localparam int WORD_W = 16;
	localparam int ADDR_W = 4;
	localparam int BYTE_W = 8;
	// ==========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
	localparam logic [ADDR_W-1:0] REG_DAC_ADV  = 4'h1;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h2;
	localparam logic [ADDR_W-1:0] REG_DAC_HOLD = 4'h3;
	// ==========================================================
	// control register fields
	localparam int CTRL_PGM_BIT = 0;
	localparam int CTRL_MM_BIT  = 1;
	localparam int CTRL_CNT_LSB = 2;
	localparam int CNT_W        = 3;
	localparam int CTRL_W       = 5;
	localparam int ADV_W        = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
	localparam logic [ADV_W-1:0]  ADV_RESET  = 4'h0;
	// ==========================================================
	// serial control word layout
	localparam int CW_TYPE_BIT = 15;
	localparam int CW_READ_BIT = 14;
	localparam int CW_ADDR_LSB = 11;
	localparam int CW_ADDR_W   = 3;
	localparam int CW_REG_LSB  = 8;
	localparam int CW_REG_W    = 3;
	localparam logic [CW_REG_W-1:0] CW_REG_CTRL = 3'h0;
	localparam logic [CW_REG_W-1:0] CW_REG_ADV  = 3'h1;
	// ==========================================================
	// timing
	localparam int CLK_HZ          = 25_000_000;
	localparam int SAMPLE_RATE_HZ  = 8_000;
	localparam int SAMPLE_CYCLES   = CLK_HZ / SAMPLE_RATE_HZ;
	localparam int SAMP_W          = 12;
	localparam int SCLK_HALF_DIV   = 4;
	localparam int ADV_STEP_CYCLES = 16;
	localparam int BIT_CNT_W       = 5;
endpackage

// [serial_link_if.sv]
// Purpose: word handshake between port control and the serial shifter
// Assumes: both ends on CLK_I
// Notes:   tx_load is taken only while tx_busy is low
`timescale 1ns/1ps
interface serial_link_if;
	logic [15:0] tx_word;
	logic        tx_load;
	logic        tx_busy;
	logic [15:0] rx_word;
	logic        rx_done;
	modport engine (input tx_word, tx_load, output tx_busy, rx_word, rx_done);
	modport ctrl   (output tx_word, tx_load, input tx_busy, rx_word, rx_done);
endinterface

// [serial_engine.sv]
// Purpose: serial clock divider, frame-synced word shifter in and out
// Assumes: pins sampled through two flip-flops
// Notes:   data launched on serial clock fall, sampled on rise
`timescale 1ns/1ps
module serial_engine
	import codec_port_pkg::*;
#(
	parameter int HALF_DIV = SCLK_HALF_DIV
)(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	serial_link_if.engine   lnk,
	output logic            sclk_o,
	output logic            sdata_o,
	output logic            ofs_o,
	input  wire logic       sdata_i,
	input  wire logic       ifs_i
);
	logic [7:0]           div_q;
	logic                 tgl;
	logic                 rise;
	logic                 fall;
	logic                 ifs_s1_q, ifs_s2_q, sd_s1_q, sd_s2_q;
	logic                 pend_q;
	logic [WORD_W-1:0]    pend_word_q;
	logic [WORD_W-1:0]    tx_sr_q;
	logic [BIT_CNT_W-1:0] tx_cnt_q;
	logic [WORD_W-1:0]    rx_sr_q;
	logic [BIT_CNT_W-1:0] rx_cnt_q;

	// ==========================================================
	// serial clock divider
	assign tgl  = (div_q == 8'(HALF_DIV - 1));
	assign rise = tgl & ~sclk_o;
	assign fall = tgl & sclk_o;
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			div_q  <= 8'h00;
			sclk_o <= 1'b0;
		end
		else
		begin
			div_q  <= tgl ? 8'h00 : div_q + 8'h01;
			sclk_o <= tgl ? ~sclk_o : sclk_o;
		end
	end

	// ==========================================================
	// pin synchronisers
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			{ifs_s1_q, ifs_s2_q, sd_s1_q, sd_s2_q} <= 4'h0;
		end
		else
		begin
			ifs_s1_q <= ifs_i;
			ifs_s2_q <= ifs_s1_q;
			sd_s1_q  <= sdata_i;
			sd_s2_q  <= sd_s1_q;
		end
	end

	// ==========================================================
	// transmit: frame sync then sixteen bits
	assign lnk.tx_busy = pend_q | ofs_o | (tx_cnt_q != '0);
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pend_q      <= 1'b0;
			pend_word_q <= '0;
			tx_sr_q     <= '0;
			tx_cnt_q    <= '0;
			ofs_o       <= 1'b0;
			sdata_o     <= 1'b0;
		end
		else
		begin
			if (lnk.tx_load && !lnk.tx_busy)
			begin
				pend_q      <= 1'b1;
				pend_word_q <= lnk.tx_word;
			end
			if (fall)
			begin
				if (pend_q)
				begin
					pend_q   <= 1'b0;
					ofs_o    <= 1'b1;
					tx_sr_q  <= pend_word_q;
					tx_cnt_q <= BIT_CNT_W'(WORD_W);
				end
				else if (tx_cnt_q != '0)
				begin
					ofs_o    <= 1'b0;
					sdata_o  <= tx_sr_q[WORD_W-1];
					tx_sr_q  <= {tx_sr_q[WORD_W-2:0], 1'b0};
					tx_cnt_q <= tx_cnt_q - BIT_CNT_W'(1);
				end
				else
				begin
					ofs_o <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// receive: frame sync seen, sixteen bits follow
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rx_sr_q     <= '0;
			rx_cnt_q    <= '0;
			lnk.rx_word <= '0;
			lnk.rx_done <= 1'b0;
		end
		else
		begin
			lnk.rx_done <= 1'b0;
			if (rise)
			begin
				if (rx_cnt_q == '0)
				begin
					if (ifs_s2_q)
						rx_cnt_q <= BIT_CNT_W'(WORD_W);
				end
				else
				begin
					rx_sr_q  <= {rx_sr_q[WORD_W-2:0], sd_s2_q};
					rx_cnt_q <= rx_cnt_q - BIT_CNT_W'(1);
					if (rx_cnt_q == BIT_CNT_W'(1))
					begin
						lnk.rx_word <= {rx_sr_q[WORD_W-2:0], sd_s2_q};
						lnk.rx_done <= 1'b1;
					end
				end
			end
		end
	end
endmodule // serial_engine

// [codec_cascade_port_checker.sv]
// Purpose: port-level assertions for the cascade serial port
// Assumes: serial clock half period of four cycles
// Notes:   advance setting tracked from bus writes only
`timescale 1ns/1ps
module codec_cascade_port_checker
	import codec_port_pkg::*;
#(
	parameter int SAMPLE_PERIOD = SAMPLE_CYCLES,
	parameter int ADV_STEP      = ADV_STEP_CYCLES,
	parameter int HALF_DIV      = SCLK_HALF_DIV
)(
	input wire logic        CLK_I,
	input wire logic        RESET_I,
	input wire logic [3:0]  ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [15:0] RDATA_O,
	input wire logic        SERIAL_CLOCK_O,
	input wire logic        SERIAL_DATA_O,
	input wire logic        OUTPUT_FRAME_SYNC_O,
	input wire logic        SERIAL_DATA_I,
	input wire logic        INPUT_FRAME_SYNC_I,
	input wire logic [15:0] ADC_DATA_I,
	input wire logic        ADC_SAMPLE_O,
	input wire logic [15:0] DAC_DATA_O,
	input wire logic        DAC_LOAD_O
);
	// ==========================================================
	// helper state
	logic [3:0]  adv_q;
	logic        seen_q;
	logic        ofs_q;
	logic [15:0] since_q;
	logic [7:0]  gap_q;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	always_ff @(posedge CLK_I or posedge RESET_I)
		if (RESET_I)
			adv_q <= ADV_RESET;
		else if (WR_I && ADDR_I == REG_DAC_ADV)
			adv_q <= WDATA_I[3:0];
	// a new advance voids the period in progress
	always_ff @(posedge CLK_I or posedge RESET_I)
		if (RESET_I)
			seen_q <= 1'b0;
		else if (WR_I && ADDR_I == REG_DAC_ADV)
			seen_q <= 1'b0;
		else if (DAC_LOAD_O)
			seen_q <= 1'b1;
	always_ff @(posedge CLK_I or posedge RESET_I)
		if (RESET_I)
			since_q <= 16'h0000;
		else if (DAC_LOAD_O)
			since_q <= 16'h0001;
		else if (since_q != 16'hFFFF)
			since_q <= since_q + 16'h0001;
	always_ff @(posedge CLK_I or posedge RESET_I)
		if (RESET_I)
			ofs_q <= 1'b0;
		else
			ofs_q <= OUTPUT_FRAME_SYNC_O;
	always_ff @(posedge CLK_I or posedge RESET_I)
		if (RESET_I)
			gap_q <= 8'h00;
		else if (ofs_q && !OUTPUT_FRAME_SYNC_O)
			gap_q <= 8'h7F;
		else if (gap_q != 8'h00)
			gap_q <= gap_q - 8'h01;
	// ==========================================================
	// assertions
	AST_LOAD_AT_SAMPLE: assert property (
		seen_q && adv_q == 4'h0 && DAC_LOAD_O |-> ADC_SAMPLE_O)
		else $error("dac load away from sample");
	AST_LOAD_ADVANCED: assert property (
		ADC_SAMPLE_O && seen_q && adv_q != 4'h0
		|-> since_q == 16'(adv_q) * 16'(ADV_STEP))
		else $error("dac load advance wrong");
	AST_OFS_WIDTH: assert property (
		$rose(OUTPUT_FRAME_SYNC_O)
		|-> OUTPUT_FRAME_SYNC_O [*8] ##1 !OUTPUT_FRAME_SYNC_O)
		else $error("frame sync width wrong");
	AST_OFS_GAP: assert property (
		gap_q != 8'h00 |-> !OUTPUT_FRAME_SYNC_O)
		else $error("frame sync inside word");
	AST_ADC_LEAVES: assert property (
		ADC_SAMPLE_O |-> ##[1:300] $rose(OUTPUT_FRAME_SYNC_O))
		else $error("adc word not sent");
	AST_SCLK_HALF: assert property (
		$rose(SERIAL_CLOCK_O) |-> SERIAL_CLOCK_O [*4] ##1 !SERIAL_CLOCK_O)
		else $error("serial clock high time wrong");
	AST_DAC_ON_LOAD: assert property (
		$changed(DAC_DATA_O) |-> DAC_LOAD_O)
		else $error("dac output moved without load");
	AST_RDATA_HOLD: assert property (
		!RD_I |=> $stable(RDATA_O))
		else $error("read data moved without read");
	AST_UNMAPPED_ZERO: assert property (
		RD_I && ADDR_I > REG_DAC_HOLD |=> RDATA_O == 16'h0000)
		else $error("unmapped read not zero");
	cover property (DAC_LOAD_O && ADC_SAMPLE_O);
	cover property (DAC_LOAD_O && !ADC_SAMPLE_O);
	cover property (RD_I && ADDR_I == REG_DAC_HOLD);
endmodule // codec_cascade_port_checker

// [dsp_port_model.sv]
// Purpose: host serial port model on the far side of the cascade port
// Assumes: no frame sync loopback; words sent on request
// Notes:   a released data line toggles each serial clock
`timescale 1ns/1ps
module dsp_port_model (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        sclk_i,
	input  wire logic        ofs_i,
	input  wire logic        sdo_i,
	input  wire logic        go_i,
	input  wire logic [15:0] word_i,
	output logic             sdi_o,
	output logic             ifs_o,
	output logic             busy_o,
	output logic             rx_stb_o,
	output logic      [15:0] rx_word_o
);
	logic        sclk_q;
	logic [4:0]  tx_n_q;
	logic [4:0]  rx_n_q;
	logic [15:0] tx_sh_q;
	logic [15:0] rx_sh_q;
	wire         fall = sclk_q & ~sclk_i;
	wire         rise = ~sclk_q & sclk_i;
	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i)
			sclk_q <= 1'b0;
		else
			sclk_q <= sclk_i;
	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i)
		begin
			{tx_n_q, ifs_o, sdi_o, busy_o} <= '0;
			tx_sh_q <= 16'h0000;
		end
		else if (go_i)
		begin
			busy_o <= 1'b1;
			tx_sh_q <= word_i;
			tx_n_q <= 5'h11;
		end
		else if (fall)
		begin
			ifs_o <= (tx_n_q == 5'h11);
			sdi_o <= (tx_n_q != 5'h11 && tx_n_q != 5'h00) ? tx_sh_q[15] : ~sdi_o;
			if (tx_n_q != 5'h11)
				tx_sh_q <= tx_sh_q << 1;
			if (tx_n_q != 5'h00)
				tx_n_q <= tx_n_q - 5'h01;
			busy_o <= (tx_n_q != 5'h00);
		end
	always_ff @(posedge clk_i or posedge reset_i)
		if (reset_i)
		begin
			{rx_n_q, rx_stb_o} <= '0;
			rx_sh_q <= 16'h0000;
			rx_word_o <= 16'h0000;
		end
		else
		begin
			rx_stb_o <= 1'b0;
			if (rise && rx_n_q == 5'h00 && ofs_i)
				rx_n_q <= 5'h10;
			else if (rise && rx_n_q != 5'h00)
			begin
				rx_sh_q <= {rx_sh_q[14:0], sdo_i};
				rx_word_o <= {rx_sh_q[14:0], sdo_i};
				rx_n_q <= rx_n_q - 5'h01;
				rx_stb_o <= (rx_n_q == 5'h01);
			end
		end
endmodule // dsp_port_model

// [codec_cascade_port_tb.sv]
// Purpose: self-checking bench for the cascade serial port
// Assumes: host port model on the serial side
// Notes:   sample period cut to 400 cycles
`timescale 1ns/1ps
module codec_cascade_port_tb;
	import codec_port_pkg::*;
	logic        clk = 1'b0;
	logic        rst;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        go = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [3:0]  a;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] adc = 16'h8000;
	logic [15:0] tx_word = 16'h0000;
	logic [15:0] seed = 16'h005A;
	logic [15:0] rdata, dac, rx_word, v, d;
	logic        sclk, serial_data_out, ofs, sdi, ifs, samp, load, busy, rx_stb;
	int          error_cnt = 0;
	int          checks = 0;
	int          cyc = 0;
	int          n;
	always #20 clk = ~clk;
	codec_cascade_port #(.SAMPLE_PERIOD(400), .ADV_STEP(16), .HALF_DIV(4))
	codec_cascade_port_inst (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.SERIAL_CLOCK_O(sclk), .SERIAL_DATA_O(serial_data_out),
		.OUTPUT_FRAME_SYNC_O(ofs), .SERIAL_DATA_I(sdi),
		.INPUT_FRAME_SYNC_I(ifs), .ADC_DATA_I(adc), .ADC_SAMPLE_O(samp),
		.DAC_DATA_O(dac), .DAC_LOAD_O(load));
	dsp_port_model dsp_port_model_inst (.clk_i(clk), .reset_i(rst),
		.sclk_i(sclk), .ofs_i(ofs), .sdo_i(serial_data_out), .go_i(go), .word_i(tx_word),
		.sdi_o(sdi), .ifs_o(ifs), .busy_o(busy), .rx_stb_o(rx_stb),
		.rx_word_o(rx_word));
	// ==========================================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results;
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bus_wr(input logic [3:0] ad, input logic [15:0] w);
		@(posedge clk);
		addr <= ad;
		wdata <= w;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [3:0] ad, output logic [15:0] r);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		r = rdata;
	endtask
	task automatic send(input logic [15:0] w);
		@(posedge clk);
		tx_word <= w;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do @(posedge clk); while (busy === 1'b1 && n++ < 400);
		if (n > 400) error_cnt++;
	endtask
	task automatic expect_rx(input logic [15:0] e);
		n = 0;
		while (!(rx_stb === 1'b1 && rx_word === e) && n++ < 800)
			@(posedge clk);
		if (n > 800) error_cnt++;
		check(rx_word, e);
	endtask
	task automatic wait_hi(input bit ld);
		n = 0;
		do @(posedge clk); while ((ld ? load : samp) !== 1'b1 && n++ < 1000);
		if (n > 1000) error_cnt++;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			results();
		end
	end
	// ==========================================================
	// main sequence
	initial
	begin
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		check(dac, 16'h0000);
		bus_rd(REG_CTRL, v);
		check(v, 16'(CTRL_RESET));
		bus_rd(REG_DAC_ADV, v);
		check(v, 16'(ADV_RESET));
		bus_wr(4'hC, 16'hFFFF);
		bus_wr(REG_CTRL, 16'h0007);
		bus_rd(REG_CTRL, v);
		check(v, 16'h0007);
		bus_rd(4'hC, v);
		check(v, 16'h0000);
		seed = lfsr(seed);
		adc <= seed | 16'h8000;
		wait_hi(1'b0);
		expect_rx(adc);
		for (int i = 0; i < 3; i++)
		begin
			seed = lfsr(seed);
			d = seed & 16'h7FFF;
			send(d);
			bus_rd(REG_DAC_HOLD, v);
			check(v, d);
			wait_hi(1'b1);
			check(dac, d);
		end
		// two devices counted, control word passes through
		bus_wr(REG_CTRL, 16'h000B);
		seed = lfsr(seed);
		d = 16'h8800 | (seed & 16'h02FF);
		send(d);
		expect_rx(d - 16'h0800);
		bus_rd(REG_STATUS, v);
		check(v & 16'h0007, 16'h0000);
		seed = lfsr(seed);
		d = seed & 16'h7FFF;
		send(d);
		expect_rx(d);
		bus_rd(REG_STATUS, v);
		check(v & 16'h0007, 16'h0001);
		send(d ^ 16'h0F0F);
		bus_rd(REG_DAC_HOLD, v);
		check(v, d ^ 16'h0F0F);
		bus_rd(REG_STATUS, v);
		check(v & 16'h0007, 16'h0000);
		send(16'h8007);
		bus_rd(REG_CTRL, v);
		check(v, 16'h0007);
		send(16'hC000);
		expect_rx(16'hC007);
		bus_wr(REG_CTRL, 16'h0004);
		send(16'h000B);
		bus_rd(REG_CTRL, v);
		check(v, 16'h000B);
		bus_rd(REG_DAC_HOLD, v);
		check(v, d ^ 16'h0F0F);
		for (int i = 0; i < 3; i++)
		begin
			seed = lfsr(seed);
			a = (i == 0) ? 4'h0 : (i == 1) ? seed[3:0] : 4'hF;
			bus_wr(REG_DAC_ADV, {12'h000, a});
			wait_hi(1'b0);
			wait_hi(1'b1);
			n = 0;
			while (samp !== 1'b1 && n < 400)
			begin
				@(posedge clk);
				n++;
			end
			check(16'(n), 16'(a) * 16'h0010);
		end
		results();
	end
endmodule // codec_cascade_port_tb
bind codec_cascade_port codec_cascade_port_checker #(
	.SAMPLE_PERIOD(SAMPLE_PERIOD), .ADV_STEP(ADV_STEP), .HALF_DIV(HALF_DIV))
checker_inst (.CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.SERIAL_CLOCK_O(SERIAL_CLOCK_O), .SERIAL_DATA_O(SERIAL_DATA_O),
	.OUTPUT_FRAME_SYNC_O(OUTPUT_FRAME_SYNC_O), .SERIAL_DATA_I(SERIAL_DATA_I),
	.INPUT_FRAME_SYNC_I(INPUT_FRAME_SYNC_I), .ADC_DATA_I(ADC_DATA_I),
	.ADC_SAMPLE_O(ADC_SAMPLE_O), .DAC_DATA_O(DAC_DATA_O),
	.DAC_LOAD_O(DAC_LOAD_O));
